// file: rtl/osc_clock_boot_map.svh
// Purpose: Offsets, field positions, reset values and counts of the clock and boot block
// Assumes: Included by the block's package user files by bare name
// Notes:   Definitions only
`ifndef OSC_CLOCK_BOOT_MAP_SVH
`define OSC_CLOCK_BOOT_MAP_SVH
`define STACK_PTR_OFS           8'h02
`define CLOCK_SELECT_MODE_OFS   8'h03
`define CRYSTAL_OSC_CONTROL_OFS 8'h0a
`define FAST_TRIM_OFS           8'h0b
`define BOOT_STATUS_OFS         8'h0c
`define XTAL_EN_BIT             7
`define XTAL_DRV_HI             6
`define XTAL_DRV_LO             5
`define FAST_EN_BIT             4
`define SLOW_EN_BIT             2
`define CRYSTAL_OSC_CONTROL_RST 8'h00
`define CLOCK_SELECT_MODE_RST   8'h16
`define FAST_TRIM_RST           8'h80
`define STACK_PTR_RST           8'h00
`define MODE_DIV2               8'h34
`define MODE_DIV4               8'h14
`define MODE_DIV8               8'h3c
`define MODE_DIV16              8'h1c
`define MODE_DIV32              8'h7c
`define MODE_SLOW               8'he4
`define MODE_XTAL               8'hb4
`define EDGES_DIV1              7'h01
`define EDGES_DIV2              7'h02
`define EDGES_DIV4              7'h04
`define EDGES_DIV8              7'h08
`define EDGES_DIV16             7'h10
`define EDGES_DIV32             7'h20
`define EDGES_DIV64             7'h40
`define OPT_NONE                3'h0
`define OPT_DIV2                3'h1
`define OPT_DIV4                3'h2
`define OPT_DIV8                3'h3
`define OPT_DIV16               3'h4
`define OPT_DIV32               3'h5
`define OPT_SLOW                3'h6
`define BOOT_FAST_CYC           12'h02d
`define BOOT_NORMAL_CYC         12'hbb8
`define RESET_VECTOR            11'h000
`define INT_VECTOR              11'h010
`define RESERVED_BASE           11'h7e0
`endif

// file: rtl/osc_clock_boot_pkg.sv
// Purpose: Types shared by the clock and boot block
// Assumes: Nothing
// Notes:   Constants live in osc_clock_boot_map.svh
package osc_clock_boot_pkg;
  typedef enum logic [1:0] {SRC_FAST, SRC_SLOW, SRC_XTAL} clk_src_t;
  typedef enum logic [1:0] {BOOT_HOLD, BOOT_COUNT, BOOT_RUN} boot_state_t;
endpackage : osc_clock_boot_pkg

// file: rtl/osc_clock_boot_control.sv
// Purpose: Oscillator enables, glitch-free system clock select, boot hold-off, memories
// Assumes: Oscillator outputs arrive as pins sampled on core_clk (250 MHz)
// Notes:   sys_clk is a register level built from filtered oscillator edges
`timescale 1ns/10ps
`include "osc_clock_boot_map.svh"

// How it works
// - After reset fetching starts at program address zero.
// - Interrupts vector to 0x10; top thirty-two words flagged as reserved system data.
// - Program store holds 2K words of 14 bits.
// - Power-on holds execution 45 or 3000 slow oscillator cycles.
// - 128-byte data memory, byte and bit access, indirect via pointer byte.
// - Stack lives in data memory at a software-set stack pointer.
// - Each oscillator has its own enable bit: crystal 7, fast 4, slow 2.
// - Fast and slow internal oscillators both run until boot completes.
// - Fast oscillator frequency is trimmed through a trim register.
// - Clock mode value picks fast /2../32, slow undivided or crystal undivided.
// - Boot value E4h: slow clock, fast off, watchdog on, port bit input.
// - Boot divided-fast value: fast and slow on, watchdog off, port bit input.
// - No calibration option leaves mode at default, watchdog on.
// - Crystal oscillator supports 32 kHz to 4 MHz only.
// - Crystal control register at 0x0a enables crystal with bit 7.
// - Crystal control bits 6:5 set drive: low, medium, high.
// - A clock mode write of a decoded mode value switches source and divider once the system clock is low.
module osc_clock_boot_control (
  input  wire logic        core_clk,        // 250 MHz clock
  input  wire logic        rst,             // Synchronous reset, active high
  input  wire logic        fast_osc_clk,    // Fast internal oscillator output
  input  wire logic        slow_osc_clk,    // Slow internal oscillator output
  input  wire logic        crystal_osc_clk, // Crystal oscillator output
  input  wire logic        boot_fast,       // Strap: fast boot when high
  input  wire logic [2:0]  boot_option,     // Calibration option code
  input  wire logic [7:0]  reg_addr,        // Register address
  input  wire logic [7:0]  reg_wdata,       // Register write data
  input  wire logic        reg_wr,          // Register write strobe
  input  wire logic        reg_rd,          // Register read strobe
  output logic      [7:0]  reg_rdata,       // Read data, cycle after reg_rd
  output logic             fast_osc_en,     // Fast oscillator enable
  output logic             slow_osc_en,     // Slow oscillator enable
  output logic             crystal_osc_en,  // Crystal oscillator enable
  output logic      [1:0]  crystal_drive,   // Crystal drive current
  output logic      [7:0]  fast_osc_trim,   // Fast oscillator trim
  output logic             sys_clk,         // System clock level
  output logic             run,             // Program execution allowed
  output logic             watchdog_en,     // Watchdog enable
  output logic             port_a_bit5_input, // Port A bit 5 in input mode
  input  wire logic        pc_advance,      // Step fetch address
  input  wire logic        pc_load,         // Jump
  input  wire logic [10:0] pc_load_addr,    // Jump target
  input  wire logic        int_take,        // Enter interrupt
  output logic      [10:0] fetch_pc,        // Fetch address
  output logic      [13:0] fetch_word,      // Fetched instruction
  output logic             reserved_hit,    // Fetch address in system area
  input  wire logic        prog_wr,         // Program store write
  input  wire logic [10:0] prog_waddr,      // Program store write address
  input  wire logic [13:0] prog_wdata,      // Program store write data
  input  wire logic [6:0]  dm_addr,         // Data memory address
  input  wire logic        dm_indirect,     // Address taken from byte at dm_addr
  input  wire logic        dm_wr,           // Data memory write
  input  wire logic        dm_rd,           // Data memory read
  input  wire logic        dm_bit_en,       // Bit access instead of byte
  input  wire logic [2:0]  dm_bit_sel,      // Bit index
  input  wire logic [7:0]  dm_wdata,        // Write byte, bit 0 for bit writes
  output logic      [7:0]  dm_rdata,        // Read data, cycle after dm_rd
  input  wire logic        stack_push,      // Push stack_wdata
  input  wire logic        stack_pop,       // Pop into dm_rdata
  input  wire logic [7:0]  stack_wdata      // Data to push
);
  osc_clock_boot_pkg::boot_state_t boot_reg;
  osc_clock_boot_pkg::clk_src_t    cur_src_reg, pend_src_reg, dec_src;
  logic [7:0]  xtal_ctl_reg, mode_reg, trim_reg, sp_reg, boot_mode;
  logic [11:0] boot_cnt_reg;
  logic        fast_strap_reg, wdog_reg, rst_seen_reg, sys_clk_reg, pend_reg, dec_ok;
  logic [6:0]  cur_div_reg, pend_div_reg, edge_cnt_reg, dec_div;
  logic [2:0]  lvl_reg, edge_w;
  logic [10:0] pc_reg;
  logic [13:0] prog_mem [2048];
  logic [7:0]  data_mem [128];
  logic [6:0]  dm_eff;
  logic [7:0]  rd_reg, dm_rd_reg, fw_reg;
  logic [13:0] fetch_reg;
  logic        src_edge;

  // Three-flop filter per oscillator; an edge counts when stages two and three agree
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_sync
      logic [2:0] stage_reg;
      logic       level_reg;
      always_ff @(posedge core_clk) begin
        if (rst) begin
          stage_reg <= 3'h0;
          level_reg <= 1'b0;
        end else begin
          stage_reg <= {stage_reg[1:0],
                        (ch == 0) ? fast_osc_clk : (ch == 1) ? slow_osc_clk : crystal_osc_clk};
          if (stage_reg[1] == stage_reg[2]) level_reg <= stage_reg[2];
        end
      end
      assign lvl_reg[ch] = level_reg;
      assign edge_w[ch]  = (stage_reg[1] == stage_reg[2]) && (stage_reg[2] != level_reg);
    end
  endgenerate

  // Mode value decode to source and divider
  always_comb begin
    dec_ok  = 1'b1;
    dec_src = osc_clock_boot_pkg::SRC_FAST;
    dec_div = `EDGES_DIV1;
    case (reg_wdata)
      `MODE_DIV2:  dec_div = `EDGES_DIV2;
      `MODE_DIV4:  dec_div = `EDGES_DIV4;
      `MODE_DIV8:  dec_div = `EDGES_DIV8;
      `MODE_DIV16: dec_div = `EDGES_DIV16;
      `MODE_DIV32: dec_div = `EDGES_DIV32;
      `MODE_SLOW:  dec_src = osc_clock_boot_pkg::SRC_SLOW;
      `MODE_XTAL:  dec_src = osc_clock_boot_pkg::SRC_XTAL;
      default:     dec_ok  = 1'b0;
    endcase
  end

  // Mode value loaded at boot end from the calibration option
  always_comb begin
    case (boot_option)
      `OPT_DIV2:  boot_mode = `MODE_DIV2;
      `OPT_DIV4:  boot_mode = `MODE_DIV4;
      `OPT_DIV8:  boot_mode = `MODE_DIV8;
      `OPT_DIV16: boot_mode = `MODE_DIV16;
      `OPT_DIV32: boot_mode = `MODE_DIV32;
      `OPT_SLOW:  boot_mode = `MODE_SLOW;
      default:    boot_mode = mode_reg;
    endcase
  end

  // Boot sequencer: catch strap after release, count slow oscillator rising edges
  always_ff @(posedge core_clk) begin
    if (rst) begin
      boot_reg       <= osc_clock_boot_pkg::BOOT_HOLD;
      boot_cnt_reg   <= 12'h000;
      fast_strap_reg <= 1'b0;
      rst_seen_reg   <= 1'b0;
    end else begin
      case (boot_reg)
        osc_clock_boot_pkg::BOOT_HOLD: begin
          fast_strap_reg <= boot_fast;
          rst_seen_reg   <= 1'b1;
          boot_reg       <= osc_clock_boot_pkg::BOOT_COUNT;
        end
        osc_clock_boot_pkg::BOOT_COUNT: begin
          if (edge_w[1] && lvl_reg[1] == 1'b0) begin
            boot_cnt_reg <= boot_cnt_reg + 12'h001;
            if (boot_cnt_reg + 12'h001 ==
                (fast_strap_reg ? `BOOT_FAST_CYC : `BOOT_NORMAL_CYC))
              boot_reg <= osc_clock_boot_pkg::BOOT_RUN;
          end
        end
        osc_clock_boot_pkg::BOOT_RUN: boot_reg <= osc_clock_boot_pkg::BOOT_RUN;
        default: boot_reg <= osc_clock_boot_pkg::BOOT_HOLD;
      endcase
    end
  end

  wire boot_end = (boot_reg == osc_clock_boot_pkg::BOOT_COUNT) && edge_w[1] && !lvl_reg[1]
                  && (boot_cnt_reg + 12'h001 ==
                      (fast_strap_reg ? `BOOT_FAST_CYC : `BOOT_NORMAL_CYC));

  // Software registers, boot loads mode and watchdog
  always_ff @(posedge core_clk) begin
    if (rst) begin
      xtal_ctl_reg <= `CRYSTAL_OSC_CONTROL_RST;
      mode_reg     <= `CLOCK_SELECT_MODE_RST;
      trim_reg     <= `FAST_TRIM_RST;
      sp_reg       <= `STACK_PTR_RST;
      wdog_reg     <= 1'b1;
    end else begin
      if (boot_end) begin
        mode_reg <= boot_mode;
        wdog_reg <= (boot_option == `OPT_NONE) || (boot_option == `OPT_SLOW);
      end else if (reg_wr) begin
        case (reg_addr)
          `CRYSTAL_OSC_CONTROL_OFS: xtal_ctl_reg <= reg_wdata;
          `CLOCK_SELECT_MODE_OFS:   mode_reg     <= reg_wdata;
          `FAST_TRIM_OFS:           trim_reg     <= reg_wdata;
          `STACK_PTR_OFS:           sp_reg       <= reg_wdata;
          default: ;
        endcase
      end
      if (stack_push && !reg_wr) sp_reg <= sp_reg + 8'h01;
      else if (stack_pop && !reg_wr) sp_reg <= sp_reg - 8'h01;
    end
  end

  // Register read, data in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) rd_reg <= 8'h00;
    else if (reg_rd) begin
      case (reg_addr)
        `CRYSTAL_OSC_CONTROL_OFS: rd_reg <= xtal_ctl_reg;
        `CLOCK_SELECT_MODE_OFS:   rd_reg <= mode_reg;
        `FAST_TRIM_OFS:           rd_reg <= trim_reg;
        `STACK_PTR_OFS:           rd_reg <= sp_reg;
        `BOOT_STATUS_OFS:         rd_reg <= {3'h0, wdog_reg, cur_src_reg, sys_clk_reg, run};
        default:                  rd_reg <= 8'h00;
      endcase
    end else rd_reg <= 8'h00;
  end
  assign reg_rdata = rd_reg;

  // Oscillator enables; both internal ones forced on until boot ends
  assign run            = (boot_reg == osc_clock_boot_pkg::BOOT_RUN);
  assign fast_osc_en    = !run || mode_reg[`FAST_EN_BIT];
  assign slow_osc_en    = !run || mode_reg[`SLOW_EN_BIT];
  assign crystal_osc_en = xtal_ctl_reg[`XTAL_EN_BIT];
  assign crystal_drive  = xtal_ctl_reg[`XTAL_DRV_HI:`XTAL_DRV_LO];
  assign fast_osc_trim  = trim_reg;
  assign watchdog_en    = wdog_reg;
  assign port_a_bit5_input = 1'b1;

  // Pending selection: boot choice or a decoded mode write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_reg     <= 1'b0;
      pend_src_reg <= osc_clock_boot_pkg::SRC_SLOW;
      pend_div_reg <= `EDGES_DIV1;
    end else if (boot_end) begin
      pend_reg <= 1'b1;
      case (boot_option)
        `OPT_DIV2:  begin pend_src_reg <= osc_clock_boot_pkg::SRC_FAST; pend_div_reg <= `EDGES_DIV2; end
        `OPT_DIV4:  begin pend_src_reg <= osc_clock_boot_pkg::SRC_FAST; pend_div_reg <= `EDGES_DIV4; end
        `OPT_DIV8:  begin pend_src_reg <= osc_clock_boot_pkg::SRC_FAST; pend_div_reg <= `EDGES_DIV8; end
        `OPT_DIV16: begin pend_src_reg <= osc_clock_boot_pkg::SRC_FAST; pend_div_reg <= `EDGES_DIV16; end
        `OPT_DIV32: begin pend_src_reg <= osc_clock_boot_pkg::SRC_FAST; pend_div_reg <= `EDGES_DIV32; end
        `OPT_SLOW:  begin pend_src_reg <= osc_clock_boot_pkg::SRC_SLOW; pend_div_reg <= `EDGES_DIV1; end
        default: begin
          pend_src_reg <= fast_strap_reg ? osc_clock_boot_pkg::SRC_FAST : osc_clock_boot_pkg::SRC_SLOW;
          pend_div_reg <= fast_strap_reg ? `EDGES_DIV64 : `EDGES_DIV1;
        end
      endcase
    end else if (reg_wr && reg_addr == `CLOCK_SELECT_MODE_OFS && dec_ok) begin
      pend_reg     <= 1'b1;
      pend_src_reg <= dec_src;
      pend_div_reg <= dec_div;
    end else if (!sys_clk_reg) pend_reg <= 1'b0;
  end

  assign src_edge = (cur_src_reg == osc_clock_boot_pkg::SRC_FAST) ? edge_w[0] :
                    (cur_src_reg == osc_clock_boot_pkg::SRC_SLOW) ? edge_w[1] : edge_w[2];

  // Divider; a new selection is taken only in the low phase and restarts one edge back,
  // so the low phase after it lasts at least one whole new phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_src_reg  <= osc_clock_boot_pkg::SRC_SLOW;
      cur_div_reg  <= `EDGES_DIV1;
      edge_cnt_reg <= 7'h00;
      sys_clk_reg  <= 1'b0;
    end else if (pend_reg && !sys_clk_reg) begin
      cur_src_reg  <= pend_src_reg;
      cur_div_reg  <= pend_div_reg;
      edge_cnt_reg <= '1;
    end else if (run && src_edge) begin
      if (edge_cnt_reg + 7'h01 == cur_div_reg) begin
        edge_cnt_reg <= 7'h00;
        sys_clk_reg  <= !sys_clk_reg;
      end else edge_cnt_reg <= edge_cnt_reg + 7'h01;
    end
  end
  assign sys_clk = sys_clk_reg;

  // Program fetch address: reset vector, interrupt vector, jumps
  always_ff @(posedge core_clk) begin
    if (rst || !run) pc_reg <= `RESET_VECTOR;
    else if (int_take) pc_reg <= `INT_VECTOR;
    else if (pc_load) pc_reg <= pc_load_addr;
    else if (pc_advance) pc_reg <= pc_reg + 11'h001;
  end
  assign fetch_pc     = pc_reg;
  assign reserved_hit = (pc_reg >= `RESERVED_BASE);

  // Program store, 2K x 14
  always_ff @(posedge core_clk) begin
    if (prog_wr) prog_mem[prog_waddr] <= prog_wdata;
  end
  always_ff @(posedge core_clk) begin
    if (rst) fetch_reg <= 14'h0000;
    else fetch_reg <= prog_mem[pc_reg];
  end
  assign fetch_word = fetch_reg;

  // Data memory with direct, indirect, bit and stack access
  assign dm_eff = dm_indirect ? data_mem[dm_addr][6:0] : dm_addr;
  always_ff @(posedge core_clk) begin
    if (stack_push) data_mem[sp_reg[6:0]] <= stack_wdata;
    else if (dm_wr && dm_bit_en) data_mem[dm_eff][dm_bit_sel] <= dm_wdata[0];
    else if (dm_wr) data_mem[dm_eff] <= dm_wdata;
  end
  always_ff @(posedge core_clk) begin
    if (rst) dm_rd_reg <= 8'h00;
    else if (stack_pop) dm_rd_reg <= data_mem[sp_reg[6:0] - 7'h01];
    else if (dm_rd && dm_bit_en) dm_rd_reg <= {7'h00, data_mem[dm_eff][dm_bit_sel]};
    else if (dm_rd) dm_rd_reg <= data_mem[dm_eff];
    else dm_rd_reg <= 8'h00;
  end
  assign dm_rdata = dm_rd_reg;
endmodule : osc_clock_boot_control

// file: tb/osc_clock_boot_control_sva.sv
// Purpose: Port assertions for the clock and boot block
// Assumes: One core_clk domain, synchronous active-high reset
// Notes:   Bound into every osc_clock_boot_control instance
`timescale 1ns/10ps
module osc_clock_boot_checker (
  input wire logic        core_clk,          // Clock
  input wire logic        rst,               // Reset
  input wire logic [7:0]  reg_addr,          // Register address
  input wire logic [7:0]  reg_wdata,         // Write data
  input wire logic        reg_wr,            // Write strobe
  input wire logic        int_take,          // Interrupt entry
  input wire logic        fast_osc_en,       // Fast enable
  input wire logic        slow_osc_en,       // Slow enable
  input wire logic        crystal_osc_en,    // Crystal enable
  input wire logic [1:0]  crystal_drive,     // Crystal drive
  input wire logic [7:0]  fast_osc_trim,     // Trim value
  input wire logic        sys_clk,           // System clock level
  input wire logic        run,               // Execution allowed
  input wire logic        port_a_bit5_input, // Port bit mode
  input wire logic [10:0] fetch_pc,          // Fetch address
  input wire logic        reserved_hit       // System area flag
);
  logic wr_x;
  logic wr_m;
  logic wr_t;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Register writes once boot has handed over
  assign wr_x = run && reg_wr && reg_addr == 8'h0a;
  assign wr_m = run && reg_wr && reg_addr == 8'h03;
  assign wr_t = run && reg_wr && reg_addr == 8'h0b;

  AST_XTAL_EN: assert property (wr_x |=> crystal_osc_en == $past(reg_wdata[7]))
    else $error("crystal enable does not follow its control bit");
  AST_XTAL_DRV: assert property (wr_x |=> crystal_drive == $past(reg_wdata[6:5]))
    else $error("crystal drive does not follow its field");
  AST_OSC_EN: assert property (wr_m |=>
    {fast_osc_en, slow_osc_en} == {$past(reg_wdata[4]), $past(reg_wdata[2])})
    else $error("internal enables do not follow mode bits");
  AST_TRIM: assert property (wr_t |=> fast_osc_trim == $past(reg_wdata))
    else $error("trim output does not follow its register");
  AST_BOOT_EN: assert property (!run |-> fast_osc_en && slow_osc_en)
    else $error("internal oscillator off during boot");
  AST_FETCH_HOLD: assert property (!run |-> fetch_pc == 11'h000)
    else $error("fetch address not at zero before run");
  AST_INT_ENTRY: assert property (run && int_take |=> fetch_pc == 11'h010)
    else $error("interrupt entry address wrong");
  AST_RESERVED: assert property (reserved_hit == (fetch_pc >= 11'h7e0))
    else $error("system area flag wrong");
  AST_SYSCLK_PHASE: assert property ($changed(sys_clk) |=> $stable(sys_clk)[*2])
    else $error("short phase on system clock");
  AST_CLK_ALIVE: assert property (run |-> ##[1:400] $changed(sys_clk))
    else $error("system clock stalled");
  AST_PORT_IN: assert property (port_a_bit5_input)
    else $error("port bit not in input mode");

  cover property ($rose(run));
  cover property (wr_m && reg_wdata == 8'hb4);
  cover property (run && int_take);
endmodule : osc_clock_boot_checker

bind osc_clock_boot_control osc_clock_boot_checker i_chk (.core_clk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .int_take, .fast_osc_en, .slow_osc_en, .crystal_osc_en,
  .crystal_drive, .fast_osc_trim, .sys_clk, .run, .port_a_bit5_input, .fetch_pc,
  .reserved_hit);

// file: tb/osc_partner_model.sv
// Purpose: Oscillator and crystal waveforms seen by the clock block
// Assumes: Phases are whole core_clk cycles
// Notes:   A disabled oscillator rests low; the crystal needs start-up time
`timescale 1ns/10ps
module osc_partner_model #(
  parameter int FAST_HALF  = 3,  // Core cycles per fast phase
  parameter int SLOW_HALF  = 5,  // Core cycles per slow phase
  parameter int XTAL_HALF  = 4,  // Core cycles per crystal phase
  parameter int XTAL_START = 40  // Cycles before the crystal swings
) (
  input wire logic core_clk,        // Core clock
  input wire logic rst,             // Power-on reset
  input wire logic fast_osc_en,     // Fast enable
  input wire logic slow_osc_en,     // Slow enable
  input wire logic crystal_osc_en,  // Crystal enable
  output logic     fast_osc_clk,    // Fast waveform
  output logic     slow_osc_clk,    // Slow waveform
  output logic     crystal_osc_clk  // Crystal waveform
);
  int fc;
  int sc;
  int xc;

  // Each oscillator restarts from a still low level whenever it is off
  always_ff @(posedge core_clk) begin
    fc <= (rst || !fast_osc_en) ? 0 : fc + 1;
    sc <= (rst || !slow_osc_en) ? 0 : sc + 1;
    xc <= (rst || !crystal_osc_en) ? 0 : xc + 1;
  end
  assign fast_osc_clk = (fc / FAST_HALF) % 2 == 1;
  assign slow_osc_clk = (sc / SLOW_HALF) % 2 == 1;
  // Crystal still during start-up, then swings at 31.25 MHz, above the 32 kHz to 4 MHz band
  assign crystal_osc_clk = xc >= XTAL_START && ((xc - XTAL_START) / XTAL_HALF) % 2 == 1;
endmodule : osc_partner_model

// file: tb/osc_clock_boot_control_bench.sv
// Purpose: Self-checking bench for the clock and boot block
// Assumes: Oscillators from osc_partner_model, phases 3, 5 and 4 core cycles
// Notes:   Expected clock phases are source phase times divider
`timescale 1ns/10ps
module osc_clock_boot_control_bench;
  logic        core_clk, rst, boot_fast, reg_wr, reg_rd, pc_advance, pc_load, int_take;
  logic        prog_wr, dm_indirect, dm_wr, dm_rd, dm_bit_en, stack_push, stack_pop;
  logic        fast_osc_clk, slow_osc_clk, crystal_osc_clk, sys_clk, run, watchdog_en;
  logic        fast_osc_en, slow_osc_en, crystal_osc_en, port_a_bit5_input, reserved_hit;
  logic [2:0]  boot_option, dm_bit_sel;
  logic [1:0]  crystal_drive;
  logic [6:0]  dm_addr;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, fast_osc_trim, dm_wdata, dm_rdata, stack_wdata;
  logic [7:0]  q, r;
  logic [7:0]  stk[$];
  logic [10:0] pc_load_addr, fetch_pc, prog_waddr;
  logic [13:0] fetch_word, prog_wdata, pw;
  logic        sq;
  int          fails = 0, checked = 0, cyc = 0, sr, n;
  int          seed = 32'h0807;
  int          md[8] = '{8'h16, 8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'he4, 8'h16};
  int          hp[8] = '{192, 6, 12, 24, 48, 96, 5, 5};
  int          wd[8] = '{1, 0, 0, 0, 0, 0, 1, 1};
  int          ra[5] = '{8'h0a, 8'h0b, 8'h02, 8'h03, 8'h55};
  int          rv[5] = '{8'h00, 8'h80, 8'h00, 8'h16, 8'h00};

  osc_clock_boot_control i_dut (.core_clk, .rst, .fast_osc_clk, .slow_osc_clk,
    .crystal_osc_clk, .boot_fast, .boot_option, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .fast_osc_en, .slow_osc_en, .crystal_osc_en, .crystal_drive, .fast_osc_trim,
    .sys_clk, .run, .watchdog_en, .port_a_bit5_input, .pc_advance, .pc_load, .pc_load_addr,
    .int_take, .fetch_pc, .fetch_word, .reserved_hit, .prog_wr, .prog_waddr, .prog_wdata,
    .dm_addr, .dm_indirect, .dm_wr, .dm_rd, .dm_bit_en, .dm_bit_sel, .dm_wdata, .dm_rdata,
    .stack_push, .stack_pop, .stack_wdata);
  osc_partner_model i_osc (.core_clk, .rst, .fast_osc_en, .slow_osc_en, .crystal_osc_en,
    .fast_osc_clk, .slow_osc_clk, .crystal_osc_clk);

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Cycle ceiling and raw slow edge count since reset
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    sq <= slow_osc_clk;
    sr <= rst ? 0 : sr + int'(slow_osc_clk && !sq);
    if (cyc == 60000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick

  // One register cycle; read data taken in the cycle after the strobe
  task automatic rg(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rg

  // Data memory cycle, k = indirect, bit, write, read, push, pop
  task automatic dmc(input logic [5:0] k, input logic [6:0] a, input logic [7:0] d,
                     output logic [7:0] v);
    @(posedge core_clk);
    {dm_indirect, dm_bit_en, dm_wr, dm_rd, stack_push, stack_pop} <= k;
    dm_addr <= a;
    dm_wdata <= d;
    stack_wdata <= d;
    dm_bit_sel <= d[6:4];
    @(posedge core_clk);
    {dm_indirect, dm_bit_en, dm_wr, dm_rd, stack_push, stack_pop} <= 6'h00;
    #1 v = dm_rdata;
  endtask : dmc

  // Fetch control, k = interrupt, load, advance
  task automatic pcs(input logic [2:0] k, input logic [10:0] a);
    @(posedge core_clk);
    {int_take, pc_load, pc_advance} <= k;
    pc_load_addr <= a;
    @(posedge core_clk);
    {int_take, pc_load, pc_advance} <= 3'h0;
    #1;
  endtask : pcs

  // Length of the second whole system clock phase from now
  task automatic half(output int c);
    logic p;
    repeat (3) begin
      p = sys_clk;
      c = 0;
      while (sys_clk === p) begin
        tick();
        c++;
      end
    end
  endtask : half

  initial begin
    rst = 1'b1;
    {boot_fast, reg_wr, reg_rd, pc_advance, pc_load, int_take, prog_wr, dm_indirect} = '0;
    {dm_wr, dm_rd, dm_bit_en, stack_push, stack_pop, boot_option, reg_addr, reg_wdata} = '0;
    {pc_load_addr, prog_waddr, prog_wdata, dm_addr, dm_bit_sel, dm_wdata, stack_wdata} = '0;
    // Every boot option, then a normal-length boot
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      rst <= 1'b1;
      boot_fast <= (i < 7);
      boot_option <= 3'(i % 7);
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      for (int k = 0; k < 5; k++) begin
        rg(1'b0, 8'(ra[k]), 8'h00, q);
        chk("reset value", rv[k], q);
      end
      while (run !== 1'b1) tick();
      chk("boot edges", i < 7 ? 45 : 3000, sr);
      rg(1'b0, 8'h03, 8'h00, q);
      chk("boot mode", md[i], q);
      chk("watchdog", wd[i], watchdog_en);
      chk("fast enable", md[i][4], fast_osc_en);
      half(n);
      chk("boot clock", hp[i], n);
      $display("boot case %0d done", i);
    end
    r = 8'($random(seed));
    rg(1'b1, 8'h0b, r, q);
    rg(1'b0, 8'h0b, 8'h00, q);
    chk("trim", r, q);
    chk("trim pins", r, fast_osc_trim);
    for (int d = 1; d < 4; d++) begin
      r = {1'b1, 2'(d), 5'h00};
      rg(1'b1, 8'h0a, r, q);
      rg(1'b0, 8'h0a, 8'h00, q);
      chk("xtal ctl", r, q);
      chk("xtal drive", d, crystal_drive);
      chk("xtal enable", 1, crystal_osc_en);
    end
    $display("register test done");
    repeat (32) @(posedge crystal_osc_clk);
    tick();
    rg(1'b1, 8'h03, 8'hb4, q);
    half(n);
    chk("xtal clock", 4, n);
    rg(1'b1, 8'h03, 8'ha4, q);
    chk("fast off", 0, fast_osc_en);
    half(n);
    chk("xtal clock held", 4, n);
    rg(1'b1, 8'h03, 8'hb4, q);
    for (int i = 6; i > 0; i--) begin
      rg(1'b1, 8'h03, 8'(md[i]), q);
      rg(1'b0, 8'h03, 8'h00, q);
      chk("mode", md[i], q);
      half(n);
      chk("divided clock", hp[i], n);
    end
    rg(1'b1, 8'h0a, 8'h00, q);
    chk("xtal off", 0, crystal_osc_en);
    $display("clock switch test done");
    pcs(3'b010, 11'h7df);
    pcs(3'b001, 11'h000);
    chk("fetch top", 11'h7e0, fetch_pc);
    chk("reserved", 1, reserved_hit);
    pcs(3'b100, 11'h000);
    chk("int entry", 11'h010, fetch_pc);
    pw = 14'($random(seed));
    @(posedge core_clk);
    prog_wr <= 1'b1;
    prog_waddr <= 11'h7ff;
    prog_wdata <= pw;
    @(posedge core_clk);
    prog_wr <= 1'b0;
    pcs(3'b010, 11'h7ff);
    tick();
    chk("fetch word", pw, fetch_word);
    r = 8'($random(seed));
    dmc(6'b001000, 7'h7f, r, q);
    dmc(6'b001000, 7'h10, 8'h7f, q);
    dmc(6'b100100, 7'h10, 8'h00, q);
    chk("indirect", r, q);
    dmc(6'b001000, 7'h20, 8'h00, q);
    dmc(6'b011000, 7'h20, 8'h31, q);
    dmc(6'b000100, 7'h20, 8'h00, q);
    chk("bit set", 8'h08, q);
    rg(1'b1, 8'h02, 8'h40, q);
    for (int i = 0; i < 2; i++) begin
      stk.push_back(8'($random(seed)));
      dmc(6'b000010, 7'h00, stk[i], q);
    end
    for (int i = 0; i < 2; i++) begin
      dmc(6'b000001, 7'h00, 8'h00, q);
      chk("pop", stk.pop_back(), q);
    end
    rg(1'b0, 8'h02, 8'h00, q);
    chk("stack ptr", 8'h40, q);
    $display("memory test done");
    report_and_stop();
  end
endmodule : osc_clock_boot_control_bench
